// >>> bkpt_tag_pkg.sv
`default_nettype none
package bkpt_tag_pkg;

  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;

  localparam logic [7:0] OFS_CTRL0 = 8'h20;
  localparam logic [7:0] OFS_CTRL1 = 8'h21;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h22;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h23;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h24;
  localparam logic [7:0] OFS_DATA_LOW = 8'h25;
  localparam logic [7:0] OFS_STATUS = 8'h26;

  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_BREAK = 8'h00;

  // control register 0 fields
  localparam int unsigned POS_MODE_LO = 6;
  localparam int unsigned POS_BP1_RANGE = 3;
  localparam int unsigned POS_BP0_RANGE = 2;
  localparam logic [7:0] CTRL0_WMASK = 8'hcc;

  // control register 1 fields
  localparam int unsigned POS_DATA_EN = 6;
  localparam int unsigned POS_HIGH_MASK = 5;
  localparam int unsigned POS_LOW_MASK = 4;
  localparam int unsigned POS_BP1_RWE = 3;
  localparam int unsigned POS_BP1_RW = 2;
  localparam int unsigned POS_BP0_RWE = 1;
  localparam int unsigned POS_BP0_RW = 0;
  localparam logic [7:0] CTRL1_WMASK = 8'h7f;

  // status register fields
  localparam int unsigned POS_ST_TAGGING = 0;
  localparam int unsigned POS_ST_BP0 = 1;
  localparam int unsigned POS_ST_BP1 = 2;
  localparam int unsigned POS_ST_PEND = 3;

  // bus clock: half period in fast clock cycles
  localparam logic [3:0] BUS_HALF_CYCLES = 4'd2;

  localparam int unsigned QUEUE_DEPTH = 3;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SWI_DUAL = 2'b01,
    MODE_DEBUG_FULL = 2'b10,
    MODE_DEBUG_DUAL = 2'b11
  } break_mode_e;

endpackage : bkpt_tag_pkg
`default_nettype wire

// >>> tag_sampler.sv
`default_nettype none
module tag_sampler (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] pin_n_i,
  input wire logic fall_en_i,
  input wire logic active_i,
  output logic [1:0] tag_o,
  output logic tag_valid_o
);
  import bkpt_tag_pkg::*;

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] tag_q;
  logic [1:0] tag_d;
  logic valid_q;
  logic valid_d;
  logic [1:0] fall_q;
  logic [1:0] fall_d;

  // each pin has its own two-stage synchroniser and acts independently
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= pin_n_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  always_comb begin
    // pins that stand at the bus clock fall reach sync_q two cycles after it
    fall_d = {fall_q[0], fall_en_i};
    tag_d = 2'b00;
    valid_d = 1'b0;
    if (fall_q[1] && active_i) begin
      tag_d = ~sync_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tag_q <= 2'b00;
      valid_q <= 1'b0;
      fall_q <= 2'b00;
    end else begin
      tag_q <= tag_d;
      valid_q <= valid_d;
      fall_q <= fall_d;
    end
  end

  assign tag_o = tag_q;
  assign tag_valid_o = valid_q;

endmodule : tag_sampler
`default_nettype wire

// >>> bus_breakpoint_and_tagging.sv
// Operation
// - breakpoint 0 with rw compare enabled (ignored in swi dual mode): value 0 matches writes, 1 matches reads
// - breakpoint 1 (dual modes only): rw don't-care unless enabled in debug dual mode; 0 writes, 1 reads
// - address-high register compares address bits 15..8; resets to zero
// - address-low register compares address bits 7..0 unless bp0 range bit is 0
// - data-high compares data 15..8, or address 15..8 in dual modes
// - data-low compares data 7..0, or address low byte in dual modes
// - tag-enable command turns strobe pin into low tag, debug pin into high tag
// - tag inputs sampled on every bus clock falling edge; low requests the tag
// - pins independent: low pin tags low byte, high pin high byte, both both
// - tagging in all modes, stops when debug active; serial commands blocked meanwhile
// - tags travel with queued bytes; tagged head enters debug instead of executing
// - mode 00 off, 01 swi dual, 10 debug full, 11 debug dual
// - bp0 range bit 0 matches upper byte only, 1 matches full address
`default_nettype none
module bus_breakpoint_and_tagging (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [bkpt_tag_pkg::REG_AW-1:0] REG_ADDR_I,
  input wire logic [bkpt_tag_pkg::REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [bkpt_tag_pkg::REG_DW-1:0] REG_RDATA_O,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic [15:0] CPU_DATA_I,
  input wire logic CPU_RW_I,
  input wire logic CPU_CYCLE_I,
  input wire logic BACKGROUND_DEBUG_MODE_I,
  input wire logic TAG_ENABLE_COMMAND_I,
  input wire logic LOW_STROBE_PIN_N_I,
  input wire logic DEBUG_SERIAL_PIN_N_I,
  input wire logic QUEUE_LOAD_I,
  input wire logic QUEUE_ADVANCE_I,
  output logic BUS_CLOCK_OUT_O,
  output logic TAGGING_ACTIVE_O,
  output logic SERIAL_CMD_BLOCK_O,
  output logic SWI_REQUEST_O,
  output logic DEBUG_BREAK_O,
  output logic DEBUG_TAG_ENTRY_O
);
  import bkpt_tag_pkg::*;

  // ---------------------------------------------------------------- registers
  logic [7:0] ctrl0_q, ctrl0_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] break_addr_high_q, break_addr_high_d;
  logic [7:0] break_addr_low_q, break_addr_low_d;
  logic [7:0] break_data_high_q, break_data_high_d;
  logic [7:0] break_data_low_q, break_data_low_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] status;

  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    break_addr_high_d = break_addr_high_q;
    break_addr_low_d = break_addr_low_q;
    break_data_high_d = break_data_high_q;
    break_data_low_d = break_data_low_q;
    rdata_d = 8'h00;
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        OFS_CTRL0: ctrl0_d = REG_WDATA_I & CTRL0_WMASK;
        OFS_CTRL1: ctrl1_d = REG_WDATA_I & CTRL1_WMASK;
        OFS_ADDR_HIGH: break_addr_high_d = REG_WDATA_I;
        OFS_ADDR_LOW: break_addr_low_d = REG_WDATA_I;
        OFS_DATA_HIGH: break_data_high_d = REG_WDATA_I;
        OFS_DATA_LOW: break_data_low_d = REG_WDATA_I;
        default: ;
      endcase
    end
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        OFS_CTRL0: rdata_d = ctrl0_q;
        OFS_CTRL1: rdata_d = ctrl1_q;
        OFS_ADDR_HIGH: rdata_d = break_addr_high_q;
        OFS_ADDR_LOW: rdata_d = break_addr_low_q;
        OFS_DATA_HIGH: rdata_d = break_data_high_q;
        OFS_DATA_LOW: rdata_d = break_data_low_q;
        OFS_STATUS: rdata_d = status;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl0_q <= RST_CTRL0;
      ctrl1_q <= RST_CTRL1;
      break_addr_high_q <= RST_BREAK;
      break_addr_low_q <= RST_BREAK;
      break_data_high_q <= RST_BREAK;
      break_data_low_q <= RST_BREAK;
      rdata_q <= 8'h00;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      break_addr_high_q <= break_addr_high_d;
      break_addr_low_q <= break_addr_low_d;
      break_data_high_q <= break_data_high_d;
      break_data_low_q <= break_data_low_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------ control bits
  break_mode_e break_mode_select;
  logic bp0_range_ctrl, bp1_range_ctrl;
  logic data_compare_en, high_byte_mask, low_byte_mask;
  logic bp0_rw_compare_en, bp0_rw_value, bp1_rw_compare_en, bp1_rw_value;

  assign break_mode_select = break_mode_e'(ctrl0_q[POS_MODE_LO +: 2]);
  assign bp0_range_ctrl = ctrl0_q[POS_BP0_RANGE];
  assign bp1_range_ctrl = ctrl0_q[POS_BP1_RANGE];
  assign data_compare_en = ctrl1_q[POS_DATA_EN];
  assign high_byte_mask = ctrl1_q[POS_HIGH_MASK];
  assign low_byte_mask = ctrl1_q[POS_LOW_MASK];
  assign bp1_rw_compare_en = ctrl1_q[POS_BP1_RWE];
  assign bp1_rw_value = ctrl1_q[POS_BP1_RW];
  assign bp0_rw_compare_en = ctrl1_q[POS_BP0_RWE];
  assign bp0_rw_value = ctrl1_q[POS_BP0_RW];

  // -------------------------------------------------------- breakpoint match
  logic first_breakpoint, second_breakpoint;
  logic swi_d, swi_q, brk_d, brk_q;
  logic bp0_hit_d, bp0_hit_q, bp1_hit_d, bp1_hit_q;

  always_comb begin
    logic ah_eq, al_ok, rw0_ok, rw1_ok, dh_ok, dl_ok, dual, rw_used;
    ah_eq = 1'b0;
    al_ok = 1'b0;
    rw0_ok = 1'b0;
    rw1_ok = 1'b0;
    dh_ok = 1'b0;
    dl_ok = 1'b0;
    dual = 1'b0;
    rw_used = 1'b0;
    ah_eq = (break_addr_high_q == CPU_ADDR_I[15:8]);
    al_ok = !bp0_range_ctrl || (break_addr_low_q == CPU_ADDR_I[7:0]);
    dual = (break_mode_select == MODE_SWI_DUAL) || (break_mode_select == MODE_DEBUG_DUAL);
    // rw qualification is ignored in the software-interrupt mode
    rw_used = (break_mode_select != MODE_SWI_DUAL);
    // read cycle has CPU_RW_I high
    rw0_ok = !(rw_used && bp0_rw_compare_en) || (CPU_RW_I == bp0_rw_value);
    rw1_ok = !(rw_used && bp1_rw_compare_en) || (CPU_RW_I == bp1_rw_value);
    if (dual) begin
      dh_ok = (break_data_high_q == CPU_ADDR_I[15:8]);
      dl_ok = !bp1_range_ctrl || (break_data_low_q == CPU_ADDR_I[7:0]);
    end else begin
      dh_ok = high_byte_mask || (break_data_high_q == CPU_DATA_I[15:8]);
      dl_ok = low_byte_mask || (break_data_low_q == CPU_DATA_I[7:0]);
    end
    first_breakpoint = 1'b0;
    second_breakpoint = 1'b0;
    if (CPU_CYCLE_I && !BACKGROUND_DEBUG_MODE_I) begin
      unique case (break_mode_select)
        MODE_OFF: begin
          first_breakpoint = 1'b0;
        end
        MODE_DEBUG_FULL: begin
          first_breakpoint = ah_eq && al_ok && rw0_ok && (!data_compare_en || (dh_ok && dl_ok));
        end
        MODE_SWI_DUAL, MODE_DEBUG_DUAL: begin
          first_breakpoint = ah_eq && al_ok && rw0_ok;
          second_breakpoint = data_compare_en && dh_ok && dl_ok && rw1_ok;
        end
      endcase
    end
    swi_d = (break_mode_select == MODE_SWI_DUAL) && (first_breakpoint || second_breakpoint);
    brk_d = break_mode_select[1] && (first_breakpoint || second_breakpoint);
    bp0_hit_d = first_breakpoint;
    bp1_hit_d = second_breakpoint;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      swi_q <= 1'b0;
      brk_q <= 1'b0;
      bp0_hit_q <= 1'b0;
      bp1_hit_q <= 1'b0;
    end else begin
      swi_q <= swi_d;
      brk_q <= brk_d;
      bp0_hit_q <= bp0_hit_d;
      bp1_hit_q <= bp1_hit_d;
    end
  end

  // ------------------------------------------------------- bus clock divider
  logic [3:0] div_q, div_d;
  logic bus_clk_q, bus_clk_d;
  logic bus_fall;

  always_comb begin
    div_d = div_q + 4'd1;
    bus_clk_d = bus_clk_q;
    if (div_q == BUS_HALF_CYCLES - 4'd1) begin
      div_d = 4'd0;
      bus_clk_d = !bus_clk_q;
    end
  end

  assign bus_fall = (div_q == BUS_HALF_CYCLES - 4'd1) && bus_clk_q;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      div_q <= 4'd0;
      bus_clk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      bus_clk_q <= bus_clk_d;
    end
  end

  // ---------------------------------------------------------------- tagging
  logic tagging_q, tagging_d;
  logic [1:0] sampled_tag;
  logic sampled_valid;

  always_comb begin
    tagging_d = tagging_q;
    if (TAG_ENABLE_COMMAND_I) begin
      tagging_d = 1'b1;
    end
    if (BACKGROUND_DEBUG_MODE_I) begin
      tagging_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tagging_q <= 1'b0;
    end else begin
      tagging_q <= tagging_d;
    end
  end

  // bit 0 low tag from the strobe pin, bit 1 high tag from the debug pin
  tag_sampler u_tag_sampler (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .pin_n_i({DEBUG_SERIAL_PIN_N_I, LOW_STROBE_PIN_N_I}),
    .fall_en_i(bus_fall),
    .active_i(tagging_q),
    .tag_o(sampled_tag),
    .tag_valid_o(sampled_valid)
  );

  // -------------------------------------------------------- instruction queue
  logic [1:0] pend_q, pend_d;
  logic [1:0] qtag_q [QUEUE_DEPTH];
  logic [1:0] qtag_d [QUEUE_DEPTH];
  logic [1:0] qcnt_q, qcnt_d;
  logic entry_q, entry_d;

  always_comb begin
    logic [1:0] pend_now;
    logic [1:0] wr_idx;
    pend_now = pend_q;
    wr_idx = 2'd0;
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      qtag_d[i] = qtag_q[i];
    end
    qcnt_d = qcnt_q;
    entry_d = 1'b0;
    if (sampled_valid) begin
      pend_now = pend_q | sampled_tag;
    end
    pend_d = pend_now;
    wr_idx = qcnt_q;
    if (QUEUE_ADVANCE_I && (qcnt_q != 2'd0)) begin
      entry_d = (qtag_q[0] != 2'b00) && !BACKGROUND_DEBUG_MODE_I;
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
        qtag_d[i] = qtag_q[i+1];
      end
      qtag_d[QUEUE_DEPTH-1] = 2'b00;
      qcnt_d = qcnt_q - 2'd1;
      wr_idx = qcnt_q - 2'd1;
    end
    if (QUEUE_LOAD_I && (wr_idx < 2'(QUEUE_DEPTH))) begin
      qtag_d[wr_idx] = pend_now;
      qcnt_d = wr_idx + 2'd1;
      pend_d = 2'b00;
    end
    if (BACKGROUND_DEBUG_MODE_I) begin
      pend_d = 2'b00;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pend_q <= 2'b00;
      qcnt_q <= 2'd0;
      entry_q <= 1'b0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        qtag_q[i] <= 2'b00;
      end
    end else begin
      pend_q <= pend_d;
      qcnt_q <= qcnt_d;
      entry_q <= entry_d;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        qtag_q[i] <= qtag_d[i];
      end
    end
  end

  // ----------------------------------------------------------------- outputs
  always_comb begin
    status = 8'h00;
    status[POS_ST_TAGGING] = tagging_q;
    status[POS_ST_BP0] = bp0_hit_q;
    status[POS_ST_BP1] = bp1_hit_q;
    status[POS_ST_PEND] = (pend_q != 2'b00);
  end

  assign REG_RDATA_O = rdata_q;
  assign BUS_CLOCK_OUT_O = bus_clk_q;
  assign TAGGING_ACTIVE_O = tagging_q;
  assign SERIAL_CMD_BLOCK_O = tagging_q;
  assign SWI_REQUEST_O = swi_q;
  assign DEBUG_BREAK_O = brk_q;
  assign DEBUG_TAG_ENTRY_O = entry_q;

endmodule : bus_breakpoint_and_tagging
`default_nettype wire

// >>> tag_tool_model.sv
`default_nettype none
module tag_tool_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_clk_i,
  input wire logic [1:0] want_i,
  output logic low_pin_n_o,
  output logic high_pin_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bus_q;
  // pins move just after a bus clock rise, so they sit still across the next fall
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= 1'b0;
      low_pin_n_o <= 1'b1;
      high_pin_n_o <= 1'b1;
    end else begin
      bus_q <= bus_clk_i;
      if (bus_clk_i && !bus_q) begin
        low_pin_n_o <= ~want_i[0];
        high_pin_n_o <= ~want_i[1];
      end
    end
  end
endmodule : tag_tool_model
`default_nettype wire

// >>> bus_breakpoint_and_tagging_checker.sv
`default_nettype none
module bkpt_checker (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic CPU_RW_I,
  input wire logic CPU_CYCLE_I,
  input wire logic BACKGROUND_DEBUG_MODE_I,
  input wire logic TAG_ENABLE_COMMAND_I,
  input wire logic QUEUE_ADVANCE_I,
  input wire logic BUS_CLOCK_OUT_O,
  input wire logic TAGGING_ACTIVE_O,
  input wire logic SERIAL_CMD_BLOCK_O,
  input wire logic DEBUG_BREAK_O,
  input wire logic DEBUG_TAG_ENTRY_O
);
  import bkpt_tag_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // shadow of the control and compare registers at 0x20..0x27
  logic [7:0] sh_q [8];
  logic [1:0] mode;
  assign mode = sh_q[0][7:6];
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sh_q <= '{default: 8'h00};
    end else if (REG_WR_I && REG_ADDR_I[7:3] == 5'h04) begin
      sh_q[REG_ADDR_I[2:0]] <= REG_WDATA_I;
    end
  end
  a_read_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside read slot");
  a_break_cause: assert property (DEBUG_BREAK_O |-> $past(mode[1]) && $past(CPU_CYCLE_I))
    else $error("break without cause");
  a_addr_high: assert property (DEBUG_BREAK_O && $past(mode) == 2'b10
    |-> $past(CPU_ADDR_I[15:8]) == $past(sh_q[2])) else $error("break on wrong high address");
  a_addr_low: assert property (DEBUG_BREAK_O && $past(mode) == 2'b10 && $past(sh_q[0][2])
    |-> $past(CPU_ADDR_I[7:0]) == $past(sh_q[3])) else $error("break on wrong low address");
  a_rw_match: assert property (DEBUG_BREAK_O && $past(mode) == 2'b10 && $past(sh_q[1][1])
    |-> $past(CPU_RW_I) == $past(sh_q[1][0])) else $error("break on wrong cycle type");
  a_tag_start: assert property (TAG_ENABLE_COMMAND_I && !BACKGROUND_DEBUG_MODE_I
    |=> TAGGING_ACTIVE_O) else $error("tagging not started");
  a_tag_stop: assert property (BACKGROUND_DEBUG_MODE_I |=> !TAGGING_ACTIVE_O)
    else $error("tagging kept in debug");
  a_cmd_block: assert property (SERIAL_CMD_BLOCK_O |-> !$past(BACKGROUND_DEBUG_MODE_I)
    && ($past(TAG_ENABLE_COMMAND_I) || $past(SERIAL_CMD_BLOCK_O)))
    else $error("serial block without tag command");
  a_entry_cause: assert property (DEBUG_TAG_ENTRY_O |-> $past(QUEUE_ADVANCE_I))
    else $error("debug entry without advance");
  a_bus_clock: assert property ($rose(BUS_CLOCK_OUT_O) |=> BUS_CLOCK_OUT_O ##1 !BUS_CLOCK_OUT_O)
    else $error("bus clock period wrong");
endmodule : bkpt_checker
bind bus_breakpoint_and_tagging bkpt_checker u_chk (.CLK_I, .RESET_I, .REG_ADDR_I, .REG_WDATA_I,
  .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .CPU_ADDR_I, .CPU_RW_I, .CPU_CYCLE_I,
  .BACKGROUND_DEBUG_MODE_I, .TAG_ENABLE_COMMAND_I, .QUEUE_ADVANCE_I, .BUS_CLOCK_OUT_O,
  .TAGGING_ACTIVE_O, .SERIAL_CMD_BLOCK_O, .DEBUG_BREAK_O, .DEBUG_TAG_ENTRY_O);
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bkpt_tag_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] cpu_data = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_rw = 1'b1, cpu_cyc = 1'b0, dbg_on = 1'b0;
  logic tag_cmd = 1'b0, q_load = 1'b0, q_adv = 1'b0;
  logic [1:0] want = 2'b00;
  logic [7:0] reg_rdata;
  logic low_pin_n, high_pin_n, bus_clk, tagging, cmd_block, swi, brk, tag_entry;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  bus_breakpoint_and_tagging uut (
    .CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .CPU_ADDR_I(cpu_addr),
    .CPU_DATA_I(cpu_data), .CPU_RW_I(cpu_rw), .CPU_CYCLE_I(cpu_cyc),
    .BACKGROUND_DEBUG_MODE_I(dbg_on), .TAG_ENABLE_COMMAND_I(tag_cmd),
    .LOW_STROBE_PIN_N_I(low_pin_n), .DEBUG_SERIAL_PIN_N_I(high_pin_n), .QUEUE_LOAD_I(q_load),
    .QUEUE_ADVANCE_I(q_adv), .BUS_CLOCK_OUT_O(bus_clk), .TAGGING_ACTIVE_O(tagging),
    .SERIAL_CMD_BLOCK_O(cmd_block), .SWI_REQUEST_O(swi), .DEBUG_BREAK_O(brk),
    .DEBUG_TAG_ENTRY_O(tag_entry));
  tag_tool_model u_tool (.clk_i(clk), .rst_i(rst), .bus_clk_i(bus_clk), .want_i(want),
    .low_pin_n_o(low_pin_n), .high_pin_n_o(high_pin_n));
  always #12.5 clk = ~clk;
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk
  // one cpu bus cycle; e holds the expected {software request, debug break}
  task automatic hit(input logic [15:0] a, input logic [15:0] d, input logic rw,
                     input logic [1:0] e);
    @(posedge clk) {cpu_cyc, cpu_addr, cpu_data, cpu_rw} <= {1'b1, a, d, rw};
    @(posedge clk) cpu_cyc <= 1'b0;
    #1 chk({6'h00, swi, brk}, {6'h00, e});
  endtask : hit
  // request tags w, load one word, advance it and look for debug entry
  task automatic word(input logic [1:0] w, input logic e);
    @(posedge clk) want <= w;
    repeat (12) @(posedge clk);
    want <= 2'b00;
    repeat (12) @(posedge clk);
    q_load <= 1'b1;
    @(posedge clk) {q_load, q_adv} <= 2'b01;
    @(posedge clk) q_adv <= 1'b0;
    #1 chk({7'h00, tag_entry}, {7'h00, e});
  endtask : word
  task automatic t_regs;
    for (int i = 0; i < 7; i++) rd_chk(8'h20 + 8'(i), 8'h00);
    for (int i = 2; i < 6; i++) wr(8'h20 + 8'(i), 8'(8'h11 * i));
    for (int i = 2; i < 6; i++) rd_chk(8'h20 + 8'(i), 8'(8'h11 * i));
    wr(8'h30, 8'h5a);
    rd_chk(8'h30, 8'h00);
    wr(OFS_CTRL0, 8'hff);
    rd_chk(OFS_CTRL0, CTRL0_WMASK);
    wr(OFS_CTRL1, 8'hff);
    rd_chk(OFS_CTRL1, CTRL1_WMASK);
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL0, 8'h00);
  endtask : t_regs
  task automatic t_break;
    wr(OFS_ADDR_HIGH, 8'h12);
    hit(16'h12ff, 16'h0, 1'b1, 2'b00);
    wr(OFS_CTRL0, 8'h80);
    hit(16'h12ff, 16'h0, 1'b1, 2'b01);
    hit(16'h13ff, 16'h0, 1'b1, 2'b00);
    wr(OFS_ADDR_LOW, 8'h34);
    wr(OFS_CTRL0, 8'h84);
    hit(16'h1234, 16'h0, 1'b1, 2'b01);
    hit(16'h1235, 16'h0, 1'b1, 2'b00);
    wr(OFS_CTRL1, 8'h02);
    hit(16'h1234, 16'h0, 1'b0, 2'b01);
    hit(16'h1234, 16'h0, 1'b1, 2'b00);
    wr(OFS_CTRL1, 8'h03);
    hit(16'h1234, 16'h0, 1'b1, 2'b01);
    wr(OFS_DATA_HIGH, 8'h56);
    wr(OFS_DATA_LOW, 8'h78);
    wr(OFS_CTRL1, 8'h40);
    hit(16'h1234, 16'h5678, 1'b1, 2'b01);
    hit(16'h1234, 16'h5679, 1'b1, 2'b00);
    hit(16'h1234, 16'h5778, 1'b1, 2'b00);
    wr(OFS_CTRL1, 8'h50);
    hit(16'h1234, 16'h5679, 1'b1, 2'b01);
    wr(OFS_DATA_HIGH, 8'hab);
    wr(OFS_DATA_LOW, 8'hcd);
    wr(OFS_CTRL1, 8'h40);
    wr(OFS_CTRL0, 8'hc0);
    hit(16'hab00, 16'h0, 1'b0, 2'b01);
    wr(OFS_CTRL0, 8'hc8);
    hit(16'habce, 16'h0, 1'b0, 2'b00);
    wr(OFS_CTRL1, 8'h4c);
    hit(16'habcd, 16'h0, 1'b1, 2'b01);
    hit(16'habcd, 16'h0, 1'b0, 2'b00);
    wr(OFS_CTRL1, 8'h44);
    hit(16'habcd, 16'h0, 1'b0, 2'b01);
    wr(OFS_CTRL1, 8'h03);
    wr(OFS_CTRL0, 8'h40);
    hit(16'h12aa, 16'h0, 1'b0, 2'b10);
    wr(OFS_CTRL1, 8'h40);
    hit(16'habff, 16'h0, 1'b1, 2'b10);
    @(posedge clk) dbg_on <= 1'b1;
    hit(16'h12aa, 16'h0, 1'b0, 2'b00);
    @(posedge clk) dbg_on <= 1'b0;
    wr(OFS_CTRL0, 8'h00);
  endtask : t_break
  task automatic t_tag;
    word(2'b11, 1'b0);
    @(posedge clk) tag_cmd <= 1'b1;
    @(posedge clk) tag_cmd <= 1'b0;
    #1 chk({6'h00, cmd_block, tagging}, 8'h03);
    rd_chk(OFS_STATUS, 8'h01);
    for (int c = 0; c < 4; c++) word(2'(c), c != 0);
    @(posedge clk) dbg_on <= 1'b1;
    @(posedge clk) dbg_on <= 1'b0;
    #1 chk({6'h00, cmd_block, tagging}, 8'h00);
    word(2'b01, 1'b0);
  endtask : t_tag
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    $display("test regs done");
    t_break();
    $display("test break done");
    t_tag();
    $display("test tag done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
